// ===== rtl/xbc_host.sv
// Host-side bus partner: address latch, memory, wait, vectors, request pins
`timescale 1ns/100ps
`include "xbc_defines.svh"
// Overview of operation
// - Every bus transfer moves one whole 16-bit word on the shared lines.
// - Code 0,0,1: device drives an address, we latch it.
// - Code 0,1,1: write strobe, device drives data, we write memory.
// - Code 1,1,1: interrupt accepted, interrupters resolve priority.
// - Code 0,1,0: we drive a routine start address for the device.
// - Code 1,0,0: memory drives addressed word, address latch captures it.
// - Code 1,1,0: addressed memory drives a word, device receives it.
// - Hold master sync low 10 ms after power-up, then release.
// - Data-ready low stalls the device, each address wait under 40 us; a nearly full capture stream stalls it without limit.
// - Bus request low; grant low until request released.
module xbc_host #(
  parameter int SYNC_HOLD_CYC = `XBC_SYNC_HOLD_CYC,
  parameter int MEM_AW = 8,
  parameter int FIFO_DEPTH = `XBC_FIFO_DEPTH,
  parameter logic [15:0] BOOT_ADDR = 16'h1000,
  parameter int WAIT_CYC = 2
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Device bus control pins
  input wire logic i_bus_ctl_one,
  input wire logic i_bus_ctl_two,
  input wire logic i_bus_direction_out,
  // Data lines, three-signal form
  input wire logic [15:0] i_data,
  output logic [15:0] o_data,
  output logic o_data_oe,
  // Device handshake pins
  output logic o_master_sync_n,
  output logic o_data_ready_in,
  input wire logic [3:0] i_ext_cond_select,
  output logic o_ext_cond_in,
  input wire logic i_terminate_irq_pulse,
  // Interrupt request and trap pin
  output logic o_nmi_request_n,
  output logic o_maskable_request_n,
  input wire logic i_pc_inhibit_trap_n,
  output logic o_pc_inhibit_trap_n,
  output logic o_pc_inhibit_trap_oe,
  // Bus request and halt
  output logic o_bus_request_n,
  input wire logic i_bus_grant_n,
  output logic o_stop_start_toggle,
  input wire logic i_halt,
  // User side
  input wire logic [15:0] i_cond_bits,
  input wire logic [15:0] i_irq_vector,
  input wire logic i_irq_nmi,
  input wire logic i_irq_mask,
  input wire logic i_inhibit_pc,
  input wire logic i_dma_req,
  input wire logic i_stop_start,
  output logic o_dma_granted,
  output logic o_halted,
  output logic o_terminate_seen,
  output logic o_sync_done,
  // Captured write and interrupt-accept stream
  output logic o_rec_valid,
  output xbc_pkg::xbc_rec_t o_rec_data,
  input wire logic i_rec_ready
);
  import xbc_pkg::*;

  // Two-stage synchronisers for every device pin
  logic [23:0] s1_q, s2_q;
  always_ff @(posedge i_clk) begin
    s1_q <= {i_bus_ctl_one, i_bus_ctl_two, i_bus_direction_out, i_data,
             i_ext_cond_select, i_terminate_irq_pulse};
    s2_q <= s1_q;
  end
  logic [1:0] s3_q;
  logic s_trap1_q, s_trap2_q;
  always_ff @(posedge i_clk) begin
    s3_q <= {i_bus_grant_n, i_halt};
    s_trap1_q <= i_pc_inhibit_trap_n;
    s_trap2_q <= s_trap1_q;
  end
  logic [1:0] s4_q;
  always_ff @(posedge i_clk) begin
    s4_q <= s3_q;
  end

  xbc_code_t code;
  logic [15:0] bus_in;
  logic [3:0] cond_sel;
  logic term_in;
  assign code = xbc_code_t'(s2_q[23:21]);
  assign bus_in = s2_q[20:5];
  assign cond_sel = s2_q[4:1];
  assign term_in = s2_q[0];

  // Decode of a code value, used for several strobes
  function automatic logic is_code(input xbc_code_t c, input logic [2:0] v);
    return c == xbc_code_t'(v);
  endfunction

  xbc_state_t st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic [15:0] addr_q, addr_d, dout_q, dout_d;
  logic oe_q, oe_d, master_sync_n_q, master_sync_n_d, rdy_q, rdy_d;
  logic [2:0] prev_q, prev_d;
  logic term_q, term_d, ecnd_q, ecnd_d;
  logic tin_q, tin_d;
  logic wr_pend_q, wr_pend_d;
  logic [15:0] rdata;
  logic mem_we, fifo_wr_ready, code_new;
  xbc_rec_t rec;

  assign code_new = code != xbc_code_t'(prev_q);
  assign mem_we = code_new && is_code(code, `XBC_CODE_WSTROBE);
  assign rec = '{code: code, word: bus_in};

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    dout_d = dout_q;
    oe_d = 1'b0;
    master_sync_n_d = master_sync_n_q;
    rdy_d = rdy_q;
    prev_d = code;
    // Edge taken from the pin history, so a long pulse gives one strobe
    tin_d = term_in;
    term_d = term_in && !tin_q;
    wr_pend_d = wr_pend_q;
    ecnd_d = i_cond_bits[cond_sel];
    case (st_q)
      XBC_ST_SYNC: begin
        master_sync_n_d = 1'b0;
        rdy_d = 1'b1;
        cnt_d = cnt_q + 32'h1;
        if (cnt_q >= 32'(SYNC_HOLD_CYC)) begin
          master_sync_n_d = 1'b1;
          st_d = XBC_ST_BOOT;
        end
      end
      XBC_ST_BOOT: begin
        if (is_code(code, `XBC_CODE_VECTOR)) begin
          dout_d = BOOT_ADDR;
          oe_d = 1'b1;
        end else if (prev_q == `XBC_CODE_VECTOR) begin
          // Leave only after the start vector, else the service vector replaces it
          st_d = XBC_ST_IDLE;
        end
      end
      XBC_ST_IDLE: begin
        if (code_new && is_code(code, `XBC_CODE_ADDR)) begin
          addr_d = bus_in;
          rdy_d = 1'b0;
          cnt_d = '0;
          st_d = XBC_ST_WAIT;
        end else if (code_new && is_code(code, `XBC_CODE_EWRITE)) begin
          wr_pend_d = 1'b1;
        end else if (code_new && is_code(code, `XBC_CODE_WSTROBE)) begin
          wr_pend_d = 1'b0;
        end else if (is_code(code, `XBC_CODE_VECTOR)) begin
          dout_d = i_irq_vector;
          oe_d = 1'b1;
        end else if (is_code(code, `XBC_CODE_DTB) || is_code(code, `XBC_CODE_INDIRECT)) begin
          dout_d = rdata;
          oe_d = 1'b1;
          if (code_new && is_code(code, `XBC_CODE_INDIRECT)) begin
            st_d = XBC_ST_RESP;
          end
        end
      end
      XBC_ST_WAIT: begin
        cnt_d = cnt_q + 32'h1;
        if (cnt_q >= 32'(WAIT_CYC) || cnt_q >= 32'(`XBC_WAIT_MAX_CYC - 1)) begin
          rdy_d = 1'b1;
          st_d = XBC_ST_IDLE;
        end
      end
      XBC_ST_RESP: begin
        dout_d = rdata;
        oe_d = 1'b1;
        if (!is_code(code, `XBC_CODE_INDIRECT)) begin
          addr_d = dout_q;
          st_d = XBC_ST_IDLE;
        end
      end
      default: st_d = XBC_ST_SYNC;
    endcase
    // Never fight a device that is itself driving
    if (code.direction || !s4_q[1]) begin
      oe_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_q <= XBC_ST_SYNC;
      cnt_q <= '0;
      addr_q <= '0;
      dout_q <= '0;
      oe_q <= 1'b0;
      master_sync_n_q <= 1'b0;
      rdy_q <= 1'b1;
      prev_q <= `XBC_CODE_IDLE;
      term_q <= 1'b0;
      tin_q <= 1'b0;
      ecnd_q <= 1'b0;
      wr_pend_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
      master_sync_n_q <= master_sync_n_d;
      rdy_q <= rdy_d;
      prev_q <= prev_d;
      term_q <= term_d;
      tin_q <= tin_d;
      ecnd_q <= ecnd_d;
      wr_pend_q <= wr_pend_d;
    end
  end

  // Request pins, all registered
  logic nmi_q, msk_q, inh_q, brq_q, stp_q, gnt_q, hlt_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      nmi_q <= 1'b1;
      msk_q <= 1'b1;
      inh_q <= 1'b0;
      brq_q <= 1'b1;
      stp_q <= 1'b1;
      gnt_q <= 1'b0;
      hlt_q <= 1'b0;
    end else begin
      // Trap pulse from the device is fed back as a maskable request
      nmi_q <= !i_irq_nmi;
      msk_q <= !(i_irq_mask || !s_trap2_q) || !master_sync_n_q;
      inh_q <= i_inhibit_pc;
      brq_q <= !i_dma_req;
      stp_q <= !i_stop_start;
      gnt_q <= !s4_q[1] && !brq_q;
      hlt_q <= s4_q[0];
    end
  end

  xbc_mem #(.AW(MEM_AW)) u_mem (
    .i_clk(i_clk),
    .i_we(mem_we),
    .i_waddr(addr_q[MEM_AW-1:0]),
    .i_wdata(bus_in),
    .i_raddr(addr_d[MEM_AW-1:0]),
    .o_rdata(rdata)
  );

  xbc_fifo #(.WIDTH($bits(xbc_rec_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_wr_valid(mem_we || (code_new && is_code(code, `XBC_CODE_ACCEPT))),
    .i_wr_data(rec),
    .o_wr_ready(fifo_wr_ready),
    .o_rd_valid(o_rec_valid),
    .o_rd_data(o_rec_data),
    .i_rd_ready(i_rec_ready)
  );

  // Stall the device while the capture stream is nearly full
  logic drdy_q;
  always_ff @(posedge i_clk) begin
    drdy_q <= i_rst_b ? (rdy_d && fifo_wr_ready) : 1'b0;
  end
  assign o_data_ready_in = drdy_q;

  assign o_data = dout_q;
  assign o_data_oe = oe_q;
  assign o_master_sync_n = master_sync_n_q;
  assign o_ext_cond_in = ecnd_q;
  assign o_nmi_request_n = nmi_q;
  assign o_maskable_request_n = msk_q;
  assign o_pc_inhibit_trap_n = 1'b0;
  assign o_pc_inhibit_trap_oe = inh_q;
  assign o_bus_request_n = brq_q;
  assign o_stop_start_toggle = stp_q;
  assign o_dma_granted = gnt_q;
  assign o_halted = hlt_q;
  assign o_terminate_seen = term_q;
  assign o_sync_done = master_sync_n_q;
endmodule : xbc_host

// ===== rtl/xbc_defines.svh
// Timing counts and bus control code values for the external bus controller
`ifndef XBC_DEFINES_SVH
`define XBC_DEFINES_SVH
`define XBC_CLK_HZ 20000000
`define XBC_MICROCYCLE_NS 400
`define XBC_MICROCYCLE_CYC (`XBC_MICROCYCLE_NS * (`XBC_CLK_HZ / 1000000) / 1000)
`define XBC_SYNC_HOLD_MS 10
`define XBC_SYNC_HOLD_CYC (`XBC_SYNC_HOLD_MS * (`XBC_CLK_HZ / 1000))
`define XBC_WAIT_MAX_US 40
`define XBC_WAIT_MAX_CYC (`XBC_WAIT_MAX_US * (`XBC_CLK_HZ / 1000000))
`define XBC_CODE_IDLE 3'h0
`define XBC_CODE_ADDR 3'h1
`define XBC_CODE_VECTOR 3'h2
`define XBC_CODE_WSTROBE 3'h3
`define XBC_CODE_INDIRECT 3'h4
`define XBC_CODE_EWRITE 3'h5
`define XBC_CODE_DTB 3'h6
`define XBC_CODE_ACCEPT 3'h7
`define XBC_FIFO_DEPTH 16
`endif

// ===== rtl/xbc_pkg.sv
// Types shared by the external bus controller files
package xbc_pkg;
  // Bus control triple, bit order {ctl_one, ctl_two, direction}
  typedef struct packed {
    logic ctl_one;
    logic ctl_two;
    logic direction;
  } xbc_code_t;

  // Word captured from the bus with the code it was seen under
  typedef struct packed {
    logic [2:0] code;
    logic [15:0] word;
  } xbc_rec_t;

  typedef enum logic [2:0] {
    XBC_ST_SYNC = 3'b000,
    XBC_ST_BOOT = 3'b001,
    XBC_ST_IDLE = 3'b010,
    XBC_ST_WAIT = 3'b011,
    XBC_ST_RESP = 3'b100
  } xbc_state_t;
endpackage : xbc_pkg

// ===== rtl/xbc_fifo.sv
// Parameterised valid/ready FIFO for captured bus records
`timescale 1ns/100ps
module xbc_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Fill side
  input wire logic i_wr_valid,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_wr_ready,
  // Drain side
  output logic o_rd_valid,
  output logic [WIDTH-1:0] o_rd_data,
  input wire logic i_rd_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic [WIDTH-1:0] rd_q, rd_d;
  logic rv_q, rv_d;
  logic push, pop, take;

  always_comb begin
    push = i_wr_valid && (cnt_q != AW'(0) + (AW+1)'(DEPTH));
    take = (!rv_q || i_rd_ready) && (cnt_q != '0);
    pop = take;
    wp_d = push ? wp_q + AW'(1) : wp_q;
    rp_d = pop ? rp_q + AW'(1) : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    rd_d = take ? mem_q[rp_q] : rd_q;
    rv_d = take ? 1'b1 : (i_rd_ready ? 1'b0 : rv_q);
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wp_q] <= i_wr_data;
    end
    if (!i_rst_b) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      rv_q <= 1'b0;
      rd_q <= '0;
      o_wr_ready <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      o_wr_ready <= cnt_d < (AW+1)'(DEPTH - 1);
    end
  end

  assign o_rd_valid = rv_q;
  assign o_rd_data = rd_q;
endmodule : xbc_fifo

// ===== rtl/xbc_mem.sv
// Small word memory modelling the host side storage, registered read
`timescale 1ns/100ps
module xbc_mem #(
  parameter int AW = 8
) (
  // Clock
  input wire logic i_clk,
  // Write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [15:0] i_wdata,
  // Read port
  input wire logic [AW-1:0] i_raddr,
  output logic [15:0] o_rdata
);
  logic [15:0] mem_q [2**AW];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_q[i_raddr];
  end
endmodule : xbc_mem

// ===== verification/xbc_cpu_model.sv
// Behavioural model of the device side of the shared bus
`timescale 1ns/100ps
module xbc_cpu_model (
  // Clock and host pins
  input wire logic i_clk,
  input wire logic [15:0] i_hd,
  input wire logic i_hoe,
  input wire logic i_rdy,
  input wire logic i_breq_n,
  input wire logic i_sst,
  // Device pins
  output logic [2:0] o_code,
  output logic [15:0] o_bus,
  output logic o_gnt_n,
  output logic o_halt,
  output logic o_term,
  output logic [3:0] o_sel,
  output logic o_trap_n
);
  logic [15:0] drv;
  logic [15:0] last;
  logic ss_q;
  initial begin
    {o_code, drv, last, o_gnt_n, o_halt, o_term, o_sel, o_trap_n, ss_q} =
      {3'h0, 16'h0000, 16'h0000, 1'b1, 1'b0, 1'b0, 4'h0, 1'b1, 1'b1};
  end
  // Floating wire shows a changing pattern so a stale word never passes
  assign o_bus = o_code[0] ? drv : (i_hoe === 1'b1 ? i_hd : ~last);
  always @(posedge i_clk) last <= o_bus;
  always @(negedge i_clk) begin
    ss_q <= i_sst;
    o_gnt_n <= i_breq_n;
    if (ss_q && !i_sst) o_halt <= !o_halt;
  end
  task automatic step(input logic [2:0] c, input logic [15:0] d, input int n);
    @(negedge i_clk);
    o_code = c;
    drv = d;
    repeat (n - 1) @(negedge i_clk);
  endtask : step
  task automatic wait_rdy;
    int k;
    step(3'h0, 16'h0, 1);
    for (k = 0; k < 100 && i_rdy !== 1'b1; k++) @(posedge i_clk);
  endtask : wait_rdy
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    step(3'h1, a, 3);
    wait_rdy();
    step(3'h5, d, 3);
    step(3'h3, d, 3);
    step(3'h0, 16'h0, 3);
  endtask : wr
  task automatic rd(input logic [2:0] c, input logic [15:0] a, output logic [15:0] d);
    step(3'h1, a, 3);
    wait_rdy();
    step(c, 16'h0, 5);
    @(posedge i_clk);
    d = o_bus;
    step(3'h0, 16'h0, 3);
  endtask : rd
  task automatic vec(output logic [15:0] d);
    step(3'h2, 16'h0, 5);
    @(posedge i_clk);
    d = o_bus;
    step(3'h0, 16'h0, 3);
  endtask : vec
  task automatic irq(input logic [15:0] pc, output logic [15:0] d);
    step(3'h7, pc, 3);
    vec(d);
  endtask : irq
  task automatic branch_on_external(input logic [3:0] s);
    @(negedge i_clk);
    o_sel = s;
    repeat (3) @(negedge i_clk);
  endtask : branch_on_external
  task automatic pulse(input logic trap);
    @(negedge i_clk);
    if (trap) o_trap_n = 1'b0;
    else o_term = 1'b1;
    @(negedge i_clk);
    {o_trap_n, o_term} = 2'h2;
  endtask : pulse
endmodule : xbc_cpu_model

// ===== verification/xbc_host_monitor.sv
// Port checker for the host bus partner
`timescale 1ns/100ps
module xbc_host_monitor #(
  parameter int SYNC_HOLD_CYC = 20
) (
  // Inputs of the host
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_bus_ctl_one,
  input wire logic i_bus_ctl_two,
  input wire logic i_bus_direction_out,
  input wire logic [15:0] i_cond_bits,
  input wire logic [3:0] i_ext_cond_select,
  input wire logic i_bus_grant_n,
  input wire logic i_terminate_irq_pulse,
  // Outputs of the host
  input wire logic o_data_oe,
  input wire logic o_data_ready_in,
  input wire logic o_master_sync_n,
  input wire logic o_maskable_request_n,
  input wire logic o_ext_cond_in,
  input wire logic o_terminate_seen,
  input wire logic o_dma_granted,
  input wire logic o_sync_done
);
  import xbc_pkg::*;
  logic [2:0] code;
  logic is_addr;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  assign code = {i_bus_ctl_one, i_bus_ctl_two, i_bus_direction_out};
  assign is_addr = code == 3'h1;
  // Saturates so a long run never wraps
  always_comb cnt_d = cnt_q + {31'h0, cnt_q < 32'h10000};
  always_ff @(posedge i_clk) cnt_q <= i_rst_b ? cnt_d : 32'h0;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  dir_no_drive_a: assert property (i_bus_direction_out[*4] |-> !o_data_oe)
    else $error("host drives while device drives");
  idle_float_a: assert property ((code == 3'h0)[*5] |-> !o_data_oe)
    else $error("host drives during idle");
  read_drive_a: assert property ((code == 3'h6 && i_bus_grant_n)[*5] |-> o_data_oe)
    else $error("no drive on read code");
  indirect_drive_a: assert property ((code == 3'h4)[*5] |-> o_data_oe)
    else $error("no drive on indirect code");
  vector_drive_a: assert property ((code == 3'h2 && o_sync_done)[*5] |-> o_data_oe)
    else $error("no drive on vector code");
  addr_stall_a: assert property ($rose(is_addr) |-> ##[1:4] !o_data_ready_in)
    else $error("no stall after address");
  wait_bound_a: assert property ($fell(o_data_ready_in) |-> ##[1:799] o_data_ready_in)
    else $error("stall too long");
  ext_cond_a: assert property (($stable(i_ext_cond_select) && $stable(i_cond_bits))[*3]
    |-> o_ext_cond_in == i_cond_bits[i_ext_cond_select]) else $error("bad condition");
  sync_hold_a: assert property (cnt_q < SYNC_HOLD_CYC - 2 |-> !o_master_sync_n)
    else $error("sync released early");
  mask_off_a: assert property (!o_master_sync_n |-> o_maskable_request_n)
    else $error("maskable request during sync");
  term_pulse_a: assert property ($rose(i_terminate_irq_pulse) |-> ##[1:4] o_terminate_seen
    ##1 !o_terminate_seen) else $error("terminate pulse wrong");
  grant_seen_a: assert property ((!i_bus_grant_n)[*4] |-> o_dma_granted && !o_data_oe)
    else $error("grant not honoured");
  cover property (code == 3'h3);
  cover property (!o_data_ready_in);
  cover property (o_dma_granted);
endmodule : xbc_host_monitor
bind xbc_host xbc_host_monitor #(.SYNC_HOLD_CYC(SYNC_HOLD_CYC)) u_mon (.*);

// ===== verification/xbc_host_tb_top.sv
// Self-checking bench for the host bus partner
`timescale 1ns/100ps
module xbc_host_tb_top;
  import xbc_pkg::*;
  logic i_clk, i_rst_b, i_bus_ctl_one, i_bus_ctl_two, i_bus_direction_out, o_data_oe;
  logic o_master_sync_n, o_data_ready_in, o_ext_cond_in, i_terminate_irq_pulse, o_nmi_request_n;
  logic o_maskable_request_n, i_pc_inhibit_trap_n, o_pc_inhibit_trap_n, o_pc_inhibit_trap_oe;
  logic o_bus_request_n, i_bus_grant_n, o_stop_start_toggle, i_halt, i_irq_nmi, i_irq_mask;
  logic i_inhibit_pc, i_dma_req, i_stop_start, o_dma_granted, o_halted, o_terminate_seen;
  logic o_sync_done, o_rec_valid, i_rec_ready, trap_n;
  logic [15:0] i_data, o_data, i_cond_bits, i_irq_vector, rd;
  logic [3:0] i_ext_cond_select;
  logic [2:0] code;
  xbc_rec_t o_rec_data;
  xbc_rec_t recq[$];
  logic [15:0] ra[4] = '{16'h0000, 16'h00FF, 16'h0055, 16'h0080};
  logic [15:0] rv[4] = '{16'hFFFF, 16'h0001, 16'hA5A5, 16'h8000};
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  xbc_host #(.SYNC_HOLD_CYC(20)) uut (.*);
  xbc_cpu_model cpu (.i_clk(i_clk), .i_hd(o_data), .i_hoe(o_data_oe), .i_rdy(o_data_ready_in),
    .i_breq_n(o_bus_request_n), .i_sst(o_stop_start_toggle), .o_code(code), .o_bus(i_data),
    .o_gnt_n(i_bus_grant_n), .o_halt(i_halt), .o_term(i_terminate_irq_pulse),
    .o_sel(i_ext_cond_select), .o_trap_n(trap_n));
  assign {i_bus_ctl_one, i_bus_ctl_two, i_bus_direction_out} = code;
  // Open-drain pin with pull-up
  always_comb i_pc_inhibit_trap_n = trap_n & ~(o_pc_inhibit_trap_oe & ~o_pc_inhibit_trap_n);
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_rec_valid === 1'b1 && i_rec_ready === 1'b1) recq.push_back(o_rec_data);
    if (cyc == 6000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [18:0] seen, input logic [18:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Bounded poll, then compare
  task automatic await(ref logic s, input logic v, input string nm);
    int k;
    for (k = 0; k < 30 && s !== v; k++) @(negedge i_clk);
    chk(nm, s, v);
  endtask : await
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  initial begin
    {i_rst_b, i_irq_nmi, i_irq_mask, i_inhibit_pc, i_dma_req, i_stop_start, i_rec_ready} = 7'h01;
    i_cond_bits = 16'h0000;
    i_irq_vector = 16'h2340;
    repeat (4) @(negedge i_clk);
    i_rst_b = 1'b1;
    chk("oe", o_data_oe, 1'b0);
    i_irq_mask = 1'b1;
    repeat (10) @(negedge i_clk);
    chk("sync", o_master_sync_n, 1'b0);
    chk("mask", o_maskable_request_n, 1'b1);
    await(o_sync_done, 1'b1, "sync_done");
    i_irq_mask = 1'b0;
    cpu.vec(rd);
    chk("boot", rd, 16'h1000);
    $display("test reset and boot done");
    for (int i = 0; i < 4; i++) begin
      cpu.wr(ra[i], rv[i]);
      repeat (2) @(negedge i_clk);
      chk("rec", recq.pop_front(), {3'h3, rv[i]});
      cpu.rd(3'h6, ra[i], rd);
      chk("read", rd, rv[i]);
    end
    $display("test rows done");
    cpu.rd(3'h4, 16'h0055, rd);
    chk("indirect", rd, 16'hA5A5);
    for (int s = 0; s < 16; s++) begin
      i_cond_bits = s[0] ? (16'h1 << s) : ~(16'h1 << s);
      cpu.branch_on_external(4'(s));
      chk("cond", o_ext_cond_in, s[0]);
    end
    i_irq_nmi = 1'b1;
    await(o_nmi_request_n, 1'b0, "nmi");
    cpu.irq(16'h0123, rd);
    chk("vector", rd, 16'h2340);
    chk("accept", recq.pop_front(), {3'h7, 16'h0123});
    i_irq_nmi = 1'b0;
    cpu.pulse(1'b1);
    await(o_maskable_request_n, 1'b0, "trap");
    i_inhibit_pc = 1'b1;
    await(i_pc_inhibit_trap_n, 1'b0, "inhibit");
    i_inhibit_pc = 1'b0;
    cpu.pulse(1'b0);
    await(o_terminate_seen, 1'b1, "term");
    $display("test interrupts done");
    i_dma_req = 1'b1;
    await(o_dma_granted, 1'b1, "grant");
    i_dma_req = 1'b0;
    await(o_dma_granted, 1'b0, "release");
    i_stop_start = 1'b1;
    await(o_halted, 1'b1, "halt");
    i_stop_start = 1'b0;
    repeat (3) @(negedge i_clk);
    i_stop_start = 1'b1;
    await(o_halted, 1'b0, "run");
    $display("test grant and halt done");
    // Consumer stalls while sixteen records fill the buffer
    i_rec_ready = 1'b0;
    for (int i = 0; i < 16; i++) cpu.wr(16'(i * 3), 16'hC000 + 16'(i));
    await(o_rec_valid, 1'b1, "full");
    i_rec_ready = 1'b1;
    repeat (24) @(negedge i_clk);
    chk("count", recq.size(), 19'd16);
    for (int i = 0; i < 16; i++) chk("drain", recq.pop_front(), {3'h3, 16'hC000 + 16'(i)});
    $display("test buffer done");
    i_rst_b = 1'b0;
    repeat (4) @(negedge i_clk);
    chk("resync", o_master_sync_n, 1'b0);
    i_rst_b = 1'b1;
    $display("test second reset done");
    end_sim();
  end
endmodule : xbc_host_tb_top
